// ==== mdp_protect.v ====
`timescale 1ns/1ps
`include "mdp_regs.vh"
module mdp_protect #(
    parameter LOCK_CYC = `MDP_LOCK_CYC,
    parameter AUTO_CYC = `MDP_AUTO_CYC,
    parameter FAST_CYC = `MDP_FAST_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        supply_under_low,
    input  wire        supply_over_high,
    input  wire        supply_undervoltage_lockout_rel,
    input  wire        current_sense_input,
    input  wire        temp_over_high,
    input  wire        temp_under_low,
    input  wire        speed_command_standby,
    input  wire        sleep_n,
    input  wire        hall_in,
    output reg  [1:0]  bridge_mode,
    output reg  [2:0]  upper_on,
    output reg  [2:0]  lower_on,
    output reg         startup_mode,
    output reg  [31:0] pattern_period,
    output reg         pattern_stb,
    output wire        speed_pulse_output_o,
    output wire        speed_pulse_output_oe_n,
    output wire        rot_detect_o,
    output wire        rot_detect_oe_n,
    output wire        irq
);
    wire        uv_low_s;
    wire        uv_rel_s;
    wire        ov_s;
    wire        oc_s;
    wire        ot_hi_s;
    wire        ot_lo_s;
    wire        stby_s;
    wire        sleep_n_s;
    wire        hall_s;
    wire [8:0]  raw_in;
    wire [8:0]  syn_out;
    wire        wr_ok;
    wire        wr_stb;
    wire [7:0]  wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    wire [7:0]  rd_addr;
    reg  [31:0] rd_data;
    reg         rd_ok;
    reg  [31:0] ctrl_q;
    reg  [`MDP_NEVT-1:0] ist_q;
    reg  [`MDP_NEVT-1:0] ien_q;
    reg         uv_q;
    reg         ot_q;
    reg         lock_q;
    reg         hall_d1_q;
    reg         sleep_d1_q;
    reg         stby_d1_q;
    reg         uv_d1_q;
    reg  [31:0] per_cnt_q;
    reg  [2:0]  good_q;
    reg         stby_seen_q;
    reg         auto_run_q;
    reg  [31:0] auto_cnt_q;
    reg         spd_q;
    wire        hall_edge;
    wire        sleep_wake;
    wire        supply_back;
    wire        lock_trip;
    wire        lock_rel;
    wire [`MDP_NEVT-1:0] evt;

    assign raw_in = {hall_in, sleep_n, speed_command_standby, temp_under_low,
                     temp_over_high, current_sense_input, supply_over_high,
                     supply_undervoltage_lockout_rel, supply_under_low};
    assign {hall_s, sleep_n_s, stby_s, ot_lo_s, ot_hi_s, oc_s, ov_s, uv_rel_s,
            uv_low_s} = syn_out;

    genvar gi;
    generate
        for (gi = 0; gi < 9; gi = gi + 1) begin : g_sync
            mdp_sync u_sync (
                .aclk    (aclk),
                .aresetn (aresetn),
                .din     (raw_in[gi]),
                .dout    (syn_out[gi])
            );
        end
    endgenerate

    mdp_axil u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_stb        (wr_stb),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok),
        .wr_ok         (wr_ok)
    );

    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `MDP_REG_CTRL) || (a == `MDP_REG_STATUS) ||
                     (a == `MDP_REG_IRQ_STAT) || (a == `MDP_REG_IRQ_CLR) ||
                     (a == `MDP_REG_IRQ_EN) || (a == `MDP_REG_PERIOD);
        end
    endfunction

    assign wr_ok = mapped(wr_addr);

    assign hall_edge   = hall_s && !hall_d1_q;
    assign sleep_wake  = sleep_n_s && !sleep_d1_q;
    assign supply_back = !uv_q && uv_d1_q;
    assign lock_trip   = per_cnt_q >= LOCK_CYC - 1;
    assign lock_rel    = hall_edge && (per_cnt_q < FAST_CYC) &&
                         (good_q >= `MDP_GOOD_CYCLES - 3'h1);

    // Edges and hysteresis flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            hall_d1_q  <= 1'b0;
            sleep_d1_q <= 1'b0;
            stby_d1_q  <= 1'b0;
            uv_d1_q    <= 1'b0;
            uv_q       <= 1'b1;
            ot_q       <= 1'b0;
        end else begin
            hall_d1_q  <= hall_s;
            sleep_d1_q <= sleep_n_s;
            stby_d1_q  <= stby_s;
            uv_d1_q    <= uv_q;
            if (uv_low_s) begin
                uv_q <= 1'b1;
            end else if (uv_rel_s) begin
                uv_q <= 1'b0;
            end
            if (ot_hi_s) begin
                ot_q <= 1'b1;
            end else if (ot_lo_s) begin
                ot_q <= 1'b0;
            end
        end
    end

    // Hall period measurement and lock
    always @(posedge aclk) begin
        if (!aresetn) begin
            per_cnt_q      <= 32'h0000_0000;
            good_q         <= 3'h0;
            lock_q         <= 1'b0;
            stby_seen_q    <= 1'b0;
            auto_run_q     <= 1'b0;
            auto_cnt_q     <= 32'h0000_0000;
            pattern_period <= 32'h0000_0000;
            pattern_stb    <= 1'b0;
            startup_mode   <= 1'b1;
            spd_q          <= 1'b0;
        end else begin
            pattern_stb <= 1'b0;
            if (hall_edge) begin
                per_cnt_q <= 32'h0000_0000;
                spd_q     <= !spd_q;
                pattern_period <= per_cnt_q + 32'h0000_0001;
                pattern_stb    <= 1'b1;
                if (!startup_mode || per_cnt_q < FAST_CYC) begin
                    startup_mode <= 1'b0;
                end
                if (per_cnt_q < FAST_CYC) begin
                    if (good_q < `MDP_GOOD_CYCLES) begin
                        good_q <= good_q + 3'h1;
                    end
                end else begin
                    good_q <= 3'h0;
                end
            end else if (!lock_trip) begin
                per_cnt_q <= per_cnt_q + 32'h0000_0001;
            end
            if (sleep_wake || (stby_s && !stby_d1_q && lock_trip)) begin
                startup_mode <= 1'b1;
                good_q       <= 3'h0;
            end
            if (lock_q && stby_s) begin
                stby_seen_q <= 1'b1;
            end
            if (lock_q && stby_seen_q && !stby_s && stby_d1_q) begin
                auto_run_q <= 1'b1;
                auto_cnt_q <= 32'h0000_0000;
            end else if (auto_run_q) begin
                auto_cnt_q <= auto_cnt_q + 32'h0000_0001;
            end
            if (lock_rel || sleep_wake || supply_back ||
                (auto_run_q && auto_cnt_q >= AUTO_CYC - 1)) begin
                lock_q      <= 1'b0;
                stby_seen_q <= 1'b0;
                auto_run_q  <= 1'b0;
                per_cnt_q   <= 32'h0000_0000;
            end else if (lock_trip && !stby_s && ctrl_q[`MDP_CTRL_ENABLE]) begin
                lock_q <= 1'b1;
            end
        end
    end

    // Bridge state priority
    always @(posedge aclk) begin
        if (!aresetn) begin
            bridge_mode <= `MDP_DRV_ALLOFF;
            upper_on    <= 3'h0;
            lower_on    <= 3'h0;
        end else if (uv_q || ot_q || !ctrl_q[`MDP_CTRL_ENABLE] || stby_s) begin
            bridge_mode <= `MDP_DRV_ALLOFF;
            upper_on    <= 3'h0;
            lower_on    <= 3'h0;
        end else if (ov_s || oc_s || lock_q) begin
            bridge_mode <= `MDP_DRV_BRAKE;
            upper_on    <= 3'h0;
            lower_on    <= 3'h7;
        end else begin
            bridge_mode <= `MDP_DRV_NORMAL;
            upper_on    <= 3'h7;
            lower_on    <= 3'h7;
        end
    end

    assign speed_pulse_output_o    = 1'b0;
    assign speed_pulse_output_oe_n = !(spd_q && ctrl_q[`MDP_CTRL_SPD_ACT]);
    assign rot_detect_o            = 1'b0;
    assign rot_detect_oe_n         = !(lock_q && ctrl_q[`MDP_CTRL_RD_ACT]);

    assign evt = {lock_q, ot_q, oc_s, ov_s, uv_q};

    // Registers, set wins over clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `MDP_CTRL_RST;
            ist_q  <= {`MDP_NEVT{1'b0}};
            ien_q  <= {`MDP_NEVT{1'b0}};
        end else begin
            if (wr_stb && wr_addr == `MDP_REG_CTRL && wr_strb[0]) begin
                ctrl_q[7:0] <= wr_data[7:0];
            end
            if (wr_stb && wr_addr == `MDP_REG_IRQ_EN && wr_strb[0]) begin
                ien_q <= wr_data[`MDP_NEVT-1:0];
            end
            if (wr_stb && wr_addr == `MDP_REG_IRQ_CLR && wr_strb[0]) begin
                ist_q <= (ist_q & ~wr_data[`MDP_NEVT-1:0]) | evt;
            end else begin
                ist_q <= ist_q | evt;
            end
        end
    end

    assign irq = |(ist_q & ien_q);

    always @* begin
        rd_ok = mapped(rd_addr);
        case (rd_addr)
            `MDP_REG_CTRL:     rd_data = ctrl_q;
            `MDP_REG_STATUS:   rd_data = {25'h0, stby_s, startup_mode, evt};
            `MDP_REG_IRQ_STAT: rd_data = {27'h0, ist_q};
            `MDP_REG_IRQ_EN:   rd_data = {27'h0, ien_q};
            `MDP_REG_PERIOD:   rd_data = pattern_period;
            default:           rd_data = 32'h0000_0000;
        endcase
    end
endmodule

// ==== mdp_regs.vh ====
`ifndef MDP_REGS_VH
`define MDP_REGS_VH

// Register byte offsets
`define MDP_REG_CTRL      8'h00
`define MDP_REG_STATUS    8'h04
`define MDP_REG_IRQ_STAT  8'h08
`define MDP_REG_IRQ_CLR   8'h0C
`define MDP_REG_IRQ_EN    8'h10
`define MDP_REG_PERIOD    8'h14

// Control fields
`define MDP_CTRL_ENABLE   0
`define MDP_CTRL_SPD_ACT  1
`define MDP_CTRL_RD_ACT   2
`define MDP_CTRL_RST      32'h0000_0000

// Status / interrupt fields
`define MDP_ST_UV         0
`define MDP_ST_OV         1
`define MDP_ST_OC         2
`define MDP_ST_OT         3
`define MDP_ST_LOCK       4
`define MDP_ST_STARTUP    5
`define MDP_ST_STANDBY    6
`define MDP_NEVT          5

// Bridge drive modes
`define MDP_DRV_NORMAL    2'h0
`define MDP_DRV_ALLOFF    2'h1
`define MDP_DRV_BRAKE     2'h2

// Timing at 250 MHz
`define MDP_CLK_HZ        250000000
`define MDP_LOCK_MS       500
`define MDP_AUTO_MS       5000
`define MDP_FAST_MS       500
`define MDP_LOCK_CYC      (`MDP_CLK_HZ / 1000 * `MDP_LOCK_MS)
`define MDP_AUTO_CYC      (`MDP_CLK_HZ / 1000 * `MDP_AUTO_MS)
`define MDP_FAST_CYC      (`MDP_CLK_HZ / 1000 * `MDP_FAST_MS)
`define MDP_GOOD_CYCLES   3'h5

`endif

// ==== mdp_sync.v ====
`timescale 1ns/1ps
module mdp_sync (
    input  wire aclk,
    input  wire aresetn,
    input  wire din,
    output reg  dout
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // Accept change when 2nd and 3rd stages agree
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule

// ==== mdp_axil.v ====
`timescale 1ns/1ps
`include "mdp_regs.vh"
module mdp_axil (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         wr_stb,
    output reg  [7:0]  wr_addr,
    output reg  [31:0] wr_data,
    output reg  [3:0]  wr_strb,
    output wire [7:0]  rd_addr,
    input  wire [31:0] rd_data,
    input  wire        rd_ok,
    input  wire        wr_ok
);
    reg        aw_q;
    reg        w_q;
    reg [7:0]  awa_q;
    reg [31:0] wd_q;
    reg [3:0]  ws_q;

    assign s_axi_awready = !aw_q && !s_axi_bvalid && !wr_stb;
    assign s_axi_wready  = !w_q && !s_axi_bvalid && !wr_stb;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_addr       = s_axi_araddr;

    // Write channels taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            awa_q        <= 8'h00;
            wd_q         <= 32'h0000_0000;
            ws_q         <= 4'h0;
            wr_stb       <= 1'b0;
            wr_addr      <= 8'h00;
            wr_data      <= 32'h0000_0000;
            wr_strb      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            wr_stb <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q  <= 1'b1;
                awa_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q  <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (aw_q && w_q) begin
                aw_q    <= 1'b0;
                w_q     <= 1'b0;
                wr_stb  <= 1'b1;
                wr_addr <= awa_q;
                wr_data <= wd_q;
                wr_strb <= ws_q;
            end
            if (wr_stb) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read answer one cycle after address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
            s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ==== mdp_protect_props.sv ====
`timescale 1ns/1ps
`include "mdp_regs.vh"
module mdp_protect_chk #(
    parameter LOCK_CYC = 200
) (
    input wire       aclk,
    input wire       aresetn,
    input wire       supply_under_low,
    input wire       current_sense_input,
    input wire       temp_over_high,
    input wire       speed_command_standby,
    input wire       sleep_n,
    input wire       hall_in,
    input wire [1:0] bridge_mode,
    input wire [2:0] upper_on,
    input wire [2:0] lower_on,
    input wire       startup_mode,
    input wire       speed_pulse_output_o,
    input wire       rot_detect_o
);
    reg        hall_q;
    reg [31:0] idle_q;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    always @(posedge aclk) begin
        hall_q <= hall_in;
        if (!aresetn || (hall_in && !hall_q) || !sleep_n || speed_command_standby
                || supply_under_low)
            idle_q <= 32'h0;
        else if (idle_q != 32'hFFFF_FFFF)
            idle_q <= idle_q + 32'h1;
    end
    sequence s_uv_held; supply_under_low [*8]; endsequence
    sequence s_hot_held; temp_over_high [*8]; endsequence
    sequence s_start_soon; ##[1:12] startup_mode; endsequence
    property p_off_shape;
        bridge_mode == `MDP_DRV_ALLOFF |-> upper_on == 3'h0 && lower_on == 3'h0;
    endproperty
    a_off_shape: assert property (p_off_shape) else $error("all-off phases wrong");
    property p_brake_shape;
        bridge_mode == `MDP_DRV_BRAKE |-> upper_on == 3'h0 && lower_on == 3'h7;
    endproperty
    a_brake_shape: assert property (p_brake_shape) else $error("brake phases wrong");
    property p_uv; s_uv_held |-> bridge_mode == `MDP_DRV_ALLOFF; endproperty
    a_uv: assert property (p_uv) else $error("undervoltage not all off");
    property p_hot; s_hot_held |-> bridge_mode == `MDP_DRV_ALLOFF; endproperty
    a_hot: assert property (p_hot) else $error("overheat not all off");
    property p_oc; current_sense_input [*8] |-> bridge_mode != `MDP_DRV_NORMAL; endproperty
    a_oc: assert property (p_oc) else $error("overcurrent left drive on");
    property p_lock; idle_q == LOCK_CYC + 16 |-> bridge_mode != `MDP_DRV_NORMAL; endproperty
    a_lock: assert property (p_lock) else $error("stalled hall left drive on");
    property p_wake; $rose(sleep_n) |-> s_start_soon; endproperty
    a_wake: assert property (p_wake) else $error("no start-up after wake");
    property p_od; speed_pulse_output_o == 1'b0 && rot_detect_o == 1'b0; endproperty
    a_od: assert property (p_od) else $error("open-drain output driven high");
endmodule

bind mdp_protect mdp_protect_chk #(.LOCK_CYC(LOCK_CYC)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .supply_under_low(supply_under_low),
    .current_sense_input(current_sense_input), .temp_over_high(temp_over_high),
    .speed_command_standby(speed_command_standby), .sleep_n(sleep_n), .hall_in(hall_in),
    .bridge_mode(bridge_mode), .upper_on(upper_on), .lower_on(lower_on),
    .startup_mode(startup_mode), .speed_pulse_output_o(speed_pulse_output_o),
    .rot_detect_o(rot_detect_o)
);

// ==== mdp_bridge_model.sv ====
`timescale 1ns/1ps
module mdp_bridge_model (
    input  wire        aclk,
    input  wire [31:0] hall_per,
    input  wire        spd_o,
    input  wire        spd_oe_n,
    input  wire        rdet_o,
    input  wire        rdet_oe_n,
    output reg         hall_in,
    output wire        spd_line,
    output wire        rd_line
);
    reg [31:0] cnt_q;
    initial begin
        hall_in = 1'b0;
        cnt_q = 32'h0;
    end
    // Hall square wave, held at zero period
    always @(posedge aclk) begin
        if (hall_per == 32'h0)
            cnt_q <= 32'h0;
        else if (cnt_q + 32'h1 >= (hall_per >> 1)) begin
            cnt_q <= 32'h0;
            hall_in <= ~hall_in;
        end else
            cnt_q <= cnt_q + 32'h1;
    end
    assign spd_line = spd_oe_n ? 1'b1 : spd_o;
    assign rd_line  = rdet_oe_n ? 1'b1 : rdet_o;
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
`include "mdp_regs.vh"
module tb;
    localparam int LOCK = 200;
    localparam int AUTO = 1000;
    localparam int FAST = 150;
    localparam logic [8:0] ROWS [12] = '{9'h088, 9'h0CA, 9'h0AA, 9'h091, 9'h081, 9'h088,
                                        9'h109, 9'h009, 9'h088, 9'h0F1, 9'h08D, 9'h088};
    logic        aclk, aresetn, sleep_n, spd_s;
    logic [6:0]  flt;
    logic [31:0] hall_per, rd, s_axi_wdata;
    logic [1:0]  rs;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]   s_axi_bresp, s_axi_rresp, bridge_mode;
    wire [31:0]  s_axi_rdata, pattern_period;
    wire [2:0]   upper_on, lower_on;
    wire         hall_in, startup_mode, pattern_stb, irq, spd_line, rd_line;
    wire         spd_o, spd_oe_n, rdet_o, rdet_oe_n;
    int          mismatches, n_tests;

    mdp_protect #(.LOCK_CYC(LOCK), .AUTO_CYC(AUTO), .FAST_CYC(FAST)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .supply_under_low(flt[6]),
        .supply_undervoltage_lockout_rel(flt[5]), .supply_over_high(flt[4]),
        .current_sense_input(flt[3]), .temp_over_high(flt[2]), .temp_under_low(flt[1]),
        .speed_command_standby(flt[0]), .sleep_n(sleep_n), .hall_in(hall_in),
        .bridge_mode(bridge_mode), .upper_on(upper_on), .lower_on(lower_on),
        .startup_mode(startup_mode), .pattern_period(pattern_period),
        .pattern_stb(pattern_stb), .speed_pulse_output_o(spd_o),
        .speed_pulse_output_oe_n(spd_oe_n), .rot_detect_o(rdet_o),
        .rot_detect_oe_n(rdet_oe_n), .irq(irq)
    );
    mdp_bridge_model u_model (
        .aclk(aclk), .hall_per(hall_per), .spd_o(spd_o), .spd_oe_n(spd_oe_n),
        .rdet_o(rdet_o), .rdet_oe_n(rdet_oe_n), .hall_in(hall_in),
        .spd_line(spd_line), .rd_line(rd_line)
    );

    task automatic test_done();
        $display("Counts: %0d checks, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h got %h", nm, e, g);
        end
    endtask
    task automatic mchk(input string nm, input logic [1:0] e);
        chk(nm, {30'h0, e}, {30'h0, bridge_mode});
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic axi_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ah, wh, rh, dn;
        @(posedge aclk);
        n = 0;
        dn = 1'b0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        while (!dn && n < 100) begin
            @(negedge aclk);
            n++;
            dn = (wr ? s_axi_bvalid : s_axi_rvalid) === 1'b1;
            rs = wr ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            ah = s_axi_awready;
            wh = s_axi_wready;
            rh = s_axi_arready;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (rh) s_axi_arvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!dn) chk("axi_answer", 32'h1, 32'h0);
    endtask
    task automatic per_chk(input logic [31:0] p);
        int n;
        int k;
        n = 0;
        k = 3;
        while (k > 0 && n < 2000) begin
            @(negedge aclk);
            n++;
            if (pattern_stb === 1'b1) k--;
        end
        n_tests++;
        if ($isunknown(pattern_period) || pattern_period + 32'h1 < p || pattern_period > p + 32'h1) begin
            mismatches++;
            $display("[ERR] pattern_period expected %0d got %0d", p, pattern_period);
        end
    endtask

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        chk("watchdog", 32'h0, 32'h1);
        test_done();
    end
    initial begin
        mismatches = 0;
        n_tests = 0;
        aresetn = 1'b0;
        flt = 7'h22;
        sleep_n = 1'b1;
        hall_per = 32'h28;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        wait_cyc(10);
        mchk("reset_mode", `MDP_DRV_ALLOFF);
        chk("reset_release", 32'h1, {31'h0, spd_line});
        wait_cyc(9);
        @(posedge aclk);
        aresetn <= 1'b1;
        axi_xfer(1'b0, `MDP_REG_CTRL, 32'h0);
        chk("ctrl_reset", `MDP_CTRL_RST, rd);
        axi_xfer(1'b0, 8'h18, 32'h0);
        chk("unmapped_resp", 32'h2, {30'h0, rs});
        axi_xfer(1'b1, `MDP_REG_CTRL, 32'h7);
        chk("wr_resp", 32'h0, {30'h0, rs});
        $display("reset and map test done");
        for (int i = 0; i < 12; i++) begin
            @(posedge aclk);
            flt <= ROWS[i][8:2];
            wait_cyc(12);
            mchk("row_mode", ROWS[i][1:0]);
        end
        $display("protection table done");
        per_chk(32'h28);
        spd_s = spd_line;
        wait_cyc(60);
        chk("spd_toggle", {31'h0, !spd_s}, {31'h0, spd_line});
        @(posedge aclk);
        hall_per <= 32'h3C;
        per_chk(32'h3C);
        chk("rd_released", 32'h1, {31'h0, rd_line});
        $display("period test done");
        @(posedge aclk);
        hall_per <= 32'h0;
        wait_cyc(LOCK + 40);
        mchk("lock_mode", `MDP_DRV_BRAKE);
        chk("rd_pulled", 32'h0, {31'h0, rd_line});
        chk("irq_masked", 32'h0, {31'h0, irq});
        axi_xfer(1'b1, `MDP_REG_IRQ_EN, 32'h10);
        wait_cyc(2);
        chk("irq_on", 32'h1, {31'h0, irq});
        @(posedge aclk);
        hall_per <= 32'h28;
        wait_cyc(7 * 40 + 20);
        mchk("fast_release", `MDP_DRV_NORMAL);
        chk("irq_sticky", 32'h1, {31'h0, irq});
        axi_xfer(1'b1, `MDP_REG_IRQ_CLR, 32'h1F);
        axi_xfer(1'b0, `MDP_REG_IRQ_STAT, 32'h0);
        wait_cyc(2);
        chk("irq_stat", 32'h0, rd & 32'h1F);
        chk("irq_clear", 32'h0, {31'h0, irq});
        $display("lock and interrupt test done");
        for (int k = 0; k < 2; k++) begin
            @(posedge aclk);
            hall_per <= 32'h0;
            wait_cyc(LOCK + 40);
            mchk("relock", `MDP_DRV_BRAKE);
            @(posedge aclk);
            if (k == 0) sleep_n <= 1'b0;
            else flt <= 7'h42;
            wait_cyc(10);
            @(posedge aclk);
            sleep_n <= 1'b1;
            flt <= 7'h22;
            wait_cyc(12);
            mchk("wake_mode", `MDP_DRV_NORMAL);
            if (k == 0) chk("wake_startup", 32'h1, {31'h0, startup_mode});
        end
        $display("immediate release test done");
        @(posedge aclk);
        hall_per <= 32'h28;
        wait_cyc(100);
        chk("run_startup", 32'h0, {31'h0, startup_mode});
        @(posedge aclk);
        hall_per <= 32'h0;
        wait_cyc(LOCK + 40);
        @(posedge aclk);
        flt <= 7'h23;
        wait_cyc(10);
        mchk("stby_mode", `MDP_DRV_ALLOFF);
        @(posedge aclk);
        flt <= 7'h22;
        wait_cyc(AUTO - 30);
        mchk("auto_hold", `MDP_DRV_BRAKE);
        wait_cyc(60);
        mchk("auto_release", `MDP_DRV_NORMAL);
        chk("stop_startup", 32'h1, {31'h0, startup_mode});
        $display("auto release test done");
        test_done();
    end
endmodule
